// ---- design/iac_pkg.sv ----
package iac_pkg;

    // ------------------------------------------------------------
    // Machine cycle timing
    // ------------------------------------------------------------
    localparam logic [2:0] T_FIRST     = 3'h1;
    localparam logic [2:0] T_STROBE_A  = 3'h2;
    localparam logic [2:0] T_DATA      = 3'h3;
    localparam logic [2:0] T_LEN_FETCH = 3'h4;
    localparam logic [2:0] T_LEN_SHORT = 3'h3;

    // ------------------------------------------------------------
    // Reset values and stack steps
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_IDLE  = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [15:0] STACK_STEP = 16'h0001;
    localparam logic [15:0] STACK_PAIR = 16'h0002;

    // ------------------------------------------------------------
    // Sequencer phases, one per machine cycle
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ACK1,
        PH_ACK2,
        PH_ACK3,
        PH_PUSH_HI,
        PH_PUSH_LO,
        PH_POP_LO,
        PH_POP_HI
    } iac_phase_t;

    function automatic logic [2:0] cycleLen(input iac_phase_t ph);
        cycleLen = (ph == PH_ACK1) ? T_LEN_FETCH : T_LEN_SHORT;
    endfunction

    function automatic logic isAckPhase(input iac_phase_t ph);
        isAckPhase = (ph == PH_ACK1) || (ph == PH_ACK2) || (ph == PH_ACK3);
    endfunction

endpackage

// ---- design/iac_request_sampler.sv ----
module iac_request_sampler
    import iac_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       sampleStrobe,
    input  wire logic       maskableRequest,
    input  wire logic [3:0] vectoredReq,
    input  wire logic       eiExec,
    input  wire logic       diExec,
    input  wire logic       seqBusy,
    output logic            intEnable,
    output logic            takeMaskable
);

    typedef struct packed {
        logic ie;
        logic take;
    } iac_smp_t;

    iac_smp_t smp_reg;
    iac_smp_t smp_next;

    always_comb begin
        smp_next = smp_reg;
        // Only the maskable line may be pending; any other wins elsewhere
        smp_next.take = sampleStrobe && !seqBusy && maskableRequest
                        && smp_reg.ie && (vectoredReq == 4'h0);
        if (smp_next.take) begin
            smp_next.ie = 1'b0;
        end else if (eiExec) begin
            smp_next.ie = 1'b1;
        end else if (diExec) begin
            smp_next.ie = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            smp_reg <= '0;
        end else begin
            smp_reg <= smp_next;
        end
    end

    assign intEnable    = smp_reg.ie;
    assign takeMaskable = smp_reg.take;

endmodule

// ---- design/iac_ack_sequencer.sv ----
module iac_ack_sequencer
    import iac_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        sampleStrobe,
    input  wire logic        maskableRequest,
    input  wire logic [3:0]  vectoredReq,
    input  wire logic        eiExec,
    input  wire logic        diExec,
    input  wire logic        returnExec,
    input  wire logic [15:0] pcIn,
    input  wire logic [15:0] spIn,
    input  wire logic [7:0]  dataIn,
    output logic [15:0]      addrBus,
    output logic [7:0]       adOut,
    output logic             adOe,
    output logic             ale,
    output logic             ioMemSel,
    output logic             interruptAckStrobeN,
    output logic             readStrobeN,
    output logic             writeStrobeN,
    output logic             pcHoldInc,
    output logic             pcLoad,
    output logic [15:0]      pcLoadValue,
    output logic             spLoad,
    output logic [15:0]      spLoadValue,
    output logic             intEnable
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        iac_phase_t  phase;
        logic [2:0]  tIdx;
        logic [15:0] savedPc;
        logic [15:0] sp;
        logic [7:0]  lowByte;
        logic [7:0]  highByte;
        logic [15:0] addrBus;
        logic [7:0]  adOut;
        logic        adOe;
        logic        ale;
        logic        ioMemSel;
        logic        ackN;
        logic        rdN;
        logic        wrN;
        logic        busy;
        logic        pcLoad;
        logic [15:0] pcLoadValue;
        logic        spLoad;
        logic [15:0] spLoadValue;
    } iac_seq_t;

    iac_seq_t seq_reg;
    iac_seq_t seq_next;
    logic     takeMaskable;

    iac_request_sampler u_sampler (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .sampleStrobe    (sampleStrobe),
        .maskableRequest (maskableRequest),
        .vectoredReq     (vectoredReq),
        .eiExec          (eiExec),
        .diExec          (diExec),
        .seqBusy         (seq_reg.busy),
        .intEnable       (intEnable),
        .takeMaskable    (takeMaskable)
    );

    // ------------------------------------------------------------
    // Sequence and registered bus outputs
    // ------------------------------------------------------------
    logic [15:0] cycAddr;
    logic [7:0]  wrData;
    logic        active;
    logic        strobeT;

    always_comb begin
        seq_next        = seq_reg;
        seq_next.pcLoad = 1'b0;
        seq_next.spLoad = 1'b0;
        case (seq_reg.phase)
            PH_IDLE: begin
                // Taken pulse lands on the edge that opens T1
                if (takeMaskable) begin
                    seq_next.phase   = PH_ACK1;
                    seq_next.tIdx    = T_FIRST;
                    seq_next.savedPc = pcIn;
                    seq_next.sp      = spIn;
                end else if (returnExec) begin
                    seq_next.phase = PH_POP_LO;
                    seq_next.tIdx  = T_FIRST;
                    seq_next.sp    = spIn;
                end
            end
            default: begin
                if (seq_reg.tIdx == T_DATA) begin
                    case (seq_reg.phase)
                        PH_ACK2:   seq_next.lowByte  = dataIn;
                        PH_ACK3:   seq_next.highByte = dataIn;
                        PH_POP_LO: seq_next.lowByte  = dataIn;
                        PH_POP_HI: seq_next.highByte = dataIn;
                        default:   seq_next.lowByte  = seq_reg.lowByte;
                    endcase
                end
                if (seq_reg.tIdx == cycleLen(seq_reg.phase)) begin
                    seq_next.tIdx = T_FIRST;
                    case (seq_reg.phase)
                        PH_ACK1:    seq_next.phase = PH_ACK2;
                        PH_ACK2:    seq_next.phase = PH_ACK3;
                        PH_ACK3:    seq_next.phase = PH_PUSH_HI;
                        PH_PUSH_HI: seq_next.phase = PH_PUSH_LO;
                        PH_PUSH_LO: begin
                            seq_next.phase       = PH_IDLE;
                            seq_next.pcLoad      = 1'b1;
                            seq_next.pcLoadValue = {seq_reg.highByte, seq_reg.lowByte};
                            seq_next.spLoad      = 1'b1;
                            seq_next.spLoadValue = seq_reg.sp - STACK_PAIR;
                        end
                        PH_POP_LO:  seq_next.phase = PH_POP_HI;
                        PH_POP_HI: begin
                            seq_next.phase       = PH_IDLE;
                            seq_next.pcLoad      = 1'b1;
                            seq_next.pcLoadValue = {dataIn, seq_reg.lowByte};
                            seq_next.spLoad      = 1'b1;
                            seq_next.spLoadValue = seq_reg.sp + STACK_PAIR;
                        end
                        default:    seq_next.phase = PH_IDLE;
                    endcase
                end else begin
                    seq_next.tIdx = seq_reg.tIdx + T_FIRST;
                end
            end
        endcase

        // Outputs are worked out for the coming state so they leave flops
        case (seq_next.phase)
            PH_PUSH_HI: begin
                cycAddr = seq_next.sp - STACK_STEP;
                wrData  = seq_next.savedPc[15:8];
            end
            PH_PUSH_LO: begin
                cycAddr = seq_next.sp - STACK_PAIR;
                wrData  = seq_next.savedPc[7:0];
            end
            PH_POP_LO: begin
                cycAddr = seq_next.sp;
                wrData  = BYTE_ZERO;
            end
            PH_POP_HI: begin
                cycAddr = seq_next.sp + STACK_STEP;
                wrData  = BYTE_ZERO;
            end
            default: begin
                // Acknowledge cycles show the frozen counter; nobody decodes it
                cycAddr = seq_next.savedPc;
                wrData  = BYTE_ZERO;
            end
        endcase
        active  = (seq_next.phase != PH_IDLE);
        strobeT = active && ((seq_next.tIdx == T_STROBE_A) || (seq_next.tIdx == T_DATA));

        seq_next.busy     = active;
        seq_next.addrBus  = active ? cycAddr : ADDR_IDLE;
        seq_next.ale      = active && (seq_next.tIdx == T_FIRST);
        seq_next.ioMemSel = isAckPhase(seq_next.phase);
        seq_next.ackN     = !(strobeT && isAckPhase(seq_next.phase));
        seq_next.rdN      = !(strobeT && ((seq_next.phase == PH_POP_LO)
                                          || (seq_next.phase == PH_POP_HI)));
        seq_next.wrN      = !(strobeT && ((seq_next.phase == PH_PUSH_HI)
                                          || (seq_next.phase == PH_PUSH_LO)));
        seq_next.adOe     = seq_next.ale || !seq_next.wrN;
        seq_next.adOut    = seq_next.ale ? cycAddr[7:0] : (!seq_next.wrN ? wrData : BYTE_ZERO);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seq_reg       <= '0;
            seq_reg.phase <= PH_IDLE;
            seq_reg.ackN  <= 1'b1;
            seq_reg.rdN   <= 1'b1;
            seq_reg.wrN   <= 1'b1;
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign addrBus             = seq_reg.addrBus;
    assign adOut               = seq_reg.adOut;
    assign adOe                = seq_reg.adOe;
    assign ale                 = seq_reg.ale;
    assign ioMemSel            = seq_reg.ioMemSel;
    assign interruptAckStrobeN = seq_reg.ackN;
    assign readStrobeN         = seq_reg.rdN;
    assign writeStrobeN        = seq_reg.wrN;
    assign pcHoldInc           = seq_reg.busy;
    assign pcLoad              = seq_reg.pcLoad;
    assign pcLoadValue         = seq_reg.pcLoadValue;
    assign spLoad              = seq_reg.spLoad;
    assign spLoadValue         = seq_reg.spLoadValue;

endmodule

// ---- testbench/iac_pic_model.sv ----
module iac_prio_unit_model #(
    parameter logic [7:0] CALL_OP = 8'hC0 // Arbitrary, never checked
)(
    input  wire logic        clk_sys,
    input  wire logic        ioMemSel,
    input  wire logic        interruptAckStrobeN,
    input  wire logic        readStrobeN,
    input  wire logic [15:0] addrBus,
    input  wire logic [15:0] spIn,
    input  wire logic [15:0] callTarget,
    input  wire logic [15:0] popWord,
    output logic      [7:0]  dataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ackIdx   = 2'h0;
    logic       prevLow  = 1'b0;
    logic [7:0] lastByte = 8'h00;
    logic [7:0] drv;
    // Address ignored while acknowledging
    always_comb begin
        drv = (addrBus == spIn) ? popWord[7:0] : popWord[15:8];
        if (!interruptAckStrobeN) begin
            case (ackIdx)
                2'h0:    drv = CALL_OP;
                2'h1:    drv = callTarget[7:0];
                default: drv = callTarget[15:8];
            endcase
        end
        dataIn = (!interruptAckStrobeN || !readStrobeN) ? drv : ~lastByte;
    end
    always @(posedge clk_sys) begin
        lastByte <= dataIn;
        prevLow <= !interruptAckStrobeN;
        if (!ioMemSel) ackIdx <= 2'h0;
        else if (!interruptAckStrobeN && prevLow) ackIdx <= ackIdx + 2'h1;
    end
endmodule

// ---- testbench/iac_ack_sequencer_chk.sv ----
module iac_ack_sequencer_chk (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        sampleStrobe,
    input wire logic        maskableRequest,
    input wire logic [3:0]  vectoredReq,
    input wire logic        returnExec,
    input wire logic [15:0] addrBus,
    input wire logic [7:0]  adOut,
    input wire logic        adOe,
    input wire logic        ale,
    input wire logic        ioMemSel,
    input wire logic        interruptAckStrobeN,
    input wire logic        readStrobeN,
    input wire logic        writeStrobeN,
    input wire logic        pcHoldInc,
    input wire logic        pcLoad,
    input wire logic        spLoad,
    input wire logic        intEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_take_starts_ack: assert property (
        sampleStrobe && maskableRequest && intEnable && vectoredReq == 4'h0 && !pcHoldInc
        |=> !intEnable ##1 (ale && ioMemSel))
        else $error("ack not started");
    a_refuse_masked: assert property (
        sampleStrobe && !intEnable && !pcHoldInc ##1 !returnExec |=> !ale)
        else $error("masked request taken");
    a_ack_io_marked: assert property (
        !interruptAckStrobeN |-> ioMemSel && readStrobeN && writeStrobeN)
        else $error("ack strobe misuse");
    a_ale_one_state: assert property (
        ale |-> (adOe && adOut == addrBus[7:0]) ##1 !ale)
        else $error("address latch bad");
    a_ack_strobe_len: assert property (
        $fell(interruptAckStrobeN) |-> ##1 !interruptAckStrobeN ##1 interruptAckStrobeN)
        else $error("ack strobe length");
    a_ack_cycle_frame: assert property (
        $rose(ioMemSel) |-> ale ##4 ale ##3 ale ##3 (ale && !ioMemSel))
        else $error("ack cycle lengths");
    a_ack_span_len: assert property (
        $rose(ioMemSel) |-> ioMemSel[*8] ##1 ioMemSel[*2] ##1 !ioMemSel)
        else $error("ack span");
    a_pc_frozen: assert property (
        ioMemSel && $past(ioMemSel) |-> $stable(addrBus) && pcHoldInc && !pcLoad)
        else $error("pc moved");
    a_push_then_jump: assert property (
        $fell(ioMemSel) |-> ale ##1 (!writeStrobeN && adOe)[*2] ##1 ale
        ##1 (!writeStrobeN && adOe)[*2] ##1 (pcLoad && spLoad && !pcHoldInc))
        else $error("push order");
    a_pop_read_len: assert property (
        $fell(readStrobeN) |-> !ioMemSel ##1 !readStrobeN ##1 readStrobeN)
        else $error("pop read");
endmodule
bind iac_ack_sequencer iac_ack_sequencer_chk i_iac_ack_sequencer_chk (.*);

// ---- testbench/iac_ack_sequencer_tb_top.sv ----
`define CHK(nm, e, a) begin samplesChecked++; if ((a) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, a); end end
module iac_ack_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic [15:0] v;} iac_note_t;
    logic        clk_sys = 1'b0, rst_n = 1'b0, sampleStrobe = 1'b0, maskableRequest = 1'b0;
    logic        eiExec = 1'b0, diExec = 1'b0, returnExec = 1'b0, prevWr = 1'b1;
    logic [3:0]  vectoredReq = 4'h0;
    logic [15:0] pcIn = 16'h0000, spIn = 16'h0000, callTarget = 16'h0000, popWord = 16'h0000;
    logic [15:0] addrBus, pcLoadValue, spLoadValue;
    logic [7:0]  dataIn, adOut;
    logic        adOe, ale, ioMemSel, interruptAckStrobeN, readStrobeN, writeStrobeN;
    logic        pcHoldInc, pcLoad, spLoad, intEnable;
    int          errors = 0, samplesChecked = 0, cycles = 0, seed = 86;
    iac_note_t   notes[$];
    iac_ack_sequencer i_iac_ack_sequencer (.*);
    iac_prio_unit_model i_iac_prio_unit_model (.*);
    always #12.5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Scoreboard: monitor pairs results with notes
    // ----------------------------------------
    task automatic check(input logic [15:0] seen);
        iac_note_t n;
        if (notes.size() == 0) begin
            errors++;
            $display("unexpected result %h with nothing pending", seen);
        end else begin
            n = notes.pop_front();
            `CHK(n.nm, n.v, seen)
        end
    endtask
    always @(negedge clk_sys) begin
        if (rst_n && !writeStrobeN && prevWr) begin
            check(addrBus);
            check({8'h00, adOut});
        end
        if (rst_n && pcLoad) begin
            check(pcLoadValue);
            check(spLoadValue);
        end
        prevWr = writeStrobeN;
    end
    task automatic waitLoad();
        for (int k = 0; k < 40 && pcLoad !== 1'b1; k++) @(negedge clk_sys);
        `CHK("load", 1'b1, pcLoad)
        @(posedge clk_sys);
    endtask
    task automatic irq(input logic [3:0] vr, input logic ie);
        logic [15:0] pc, sp, tg;
        pc = 16'($random(seed));
        sp = 16'($random(seed));
        tg = 16'($random(seed));
        @(posedge clk_sys);
        eiExec <= ie;
        pcIn <= pc;
        spIn <= sp;
        callTarget <= tg;
        vectoredReq <= vr;
        maskableRequest <= 1'b1;
        @(posedge clk_sys);
        eiExec <= 1'b0;
        sampleStrobe <= 1'b1;
        @(posedge clk_sys);
        sampleStrobe <= 1'b0;
        if (ie && vr == 4'h0) begin
            notes.push_back('{"push hi addr", sp - 16'h0001});
            notes.push_back('{"push hi data", {8'h00, pc[15:8]}});
            notes.push_back('{"push lo addr", sp - 16'h0002});
            notes.push_back('{"push lo data", {8'h00, pc[7:0]}});
            notes.push_back('{"jump pc", tg});
            notes.push_back('{"jump sp", sp - 16'h0002});
            @(posedge clk_sys);
            // Core values move after capture; the saved copies must be pushed
            pcIn <= ~pc;
            spIn <= ~sp;
            waitLoad();
            `CHK("ie after ack", 1'b0, intEnable)
        end else begin
            repeat (4) @(negedge clk_sys);
            `CHK("refused busy", 1'b0, pcHoldInc)
            @(posedge clk_sys);
        end
        maskableRequest <= 1'b0;
        vectoredReq <= 4'h0;
    endtask
    task automatic ret();
        logic [15:0] sp, pw;
        sp = 16'($random(seed));
        pw = 16'($random(seed));
        @(posedge clk_sys);
        spIn <= sp;
        popWord <= pw;
        eiExec <= 1'b1;
        @(posedge clk_sys);
        eiExec <= 1'b0;
        returnExec <= 1'b1;
        @(posedge clk_sys);
        returnExec <= 1'b0;
        notes.push_back('{"pop pc", pw});
        notes.push_back('{"pop sp", sp + 16'h0002});
        waitLoad();
    endtask
    // ----------------------------------------
    // Verdict and run control
    // ----------------------------------------
    task automatic testDone();
        $display("checks %0d errors %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            testDone();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        `CHK("reset ie", 1'b0, intEnable)
        irq(4'h0, 1'b0);
        for (int i = 0; i < 4; i++) irq(4'h1 << i, 1'b1);
        `CHK("ie after enable", 1'b1, intEnable)
        diExec <= 1'b1;
        @(posedge clk_sys);
        diExec <= 1'b0;
        @(negedge clk_sys);
        `CHK("ie after disable", 1'b0, intEnable)
        repeat (4) begin
            irq(4'h0, 1'b1);
            ret();
        end
        // Mid-run reset while enable is set must clear it again
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        `CHK("ie after reset", 1'b0, intEnable)
        `CHK("busy after reset", 1'b0, pcHoldInc)
        `CHK("pending", 0, notes.size())
        testDone();
    end
endmodule
